// [verification/pmcg_latch_model.sv]
// Model of the external power-control latch fed by the clock-generator pin
`timescale 1ns/1ps
module pmcg_latch_model
(
    // Pin and byte from the block
    input wire logic clock_gen_ctl_line,
    input wire logic [7:0] companion_addr_lines,
    // Latched power outputs
    output logic [7:0] power_latch_value
);
    // Arbitrary start value, so a missed capture cannot look right
    initial power_latch_value = 8'h5A;
    // Transparent while the pin is low, holds once it returns high
    always @*
    begin
        if (clock_gen_ctl_line === 1'b0)
            power_latch_value = companion_addr_lines;
    end
endmodule // pmcg_latch_model

// [verification/pmcg_top_assertions.sv]
// Port-level assertion checker for the PM clock block
`timescale 1ns/1ps
module pmcg_top_checker
    import pmcg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // Pin, power byte and deturbo outputs
    input wire logic clock_gen_ctl_line,
    input wire logic [7:0] companion_addr_lines,
    input wire logic deturbo_via_pin,
    input wire logic deturbo_smi_req,
    input wire logic cpu_backoff
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic wr_ok; // Accepted byte write, seen in its ack cycle
    logic wr_cc; // Write to clock control
    logic wr_pw; // Write to power byte
    logic mode_q; // Latched mode; lags the design by one cycle
    logic [1:0] dt_q; // Deturbo select copy
    logic bo_q; // Back-off scheme selected
    logic [10:0] hi_q; // Length of the current back-off run
    assign wr_ok = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    assign wr_cc = wr_ok && wb_adr_i == 10'h100;
    assign wr_pw = wr_ok && wb_adr_i == 10'h104;
    // Copy clock-control fields; writes during a pulse are never issued by the bench
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_q <= 1'b0;
            dt_q <= 2'b00;
            bo_q <= 1'b0;
        end
        else if (wr_cc)
        begin
            mode_q <= wb_dat_i[2];
            dt_q <= wb_dat_i[4:3];
            bo_q <= wb_dat_i[5] && wb_dat_i[4:3] == 2'b01;
        end
    end
    // Count back-off cycles; cleared on every low cycle
    always_ff @(posedge clk)
    begin
        if (rst || !cpu_backoff)
        begin
            hi_q <= 11'h000;
        end
        else
        begin
            hi_q <= hi_q + 11'h001;
        end
    end
    a_bus_answer: assert property ($rose(wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
    a_reset_vals: assert property ($fell(rst) |-> clock_gen_ctl_line && companion_addr_lines == 8'h00)
        else $error("pin or power byte wrong after reset");
    a_level_follow: assert property (!mode_q && wr_cc && !wb_dat_i[2] |=> clock_gen_ctl_line == $past(wb_dat_i[0]))
        else $error("pin does not follow control bit");
    // The pin has already dropped by the ack edge, so look at its level one cycle earlier
    a_pulse_start: assert property (mode_q && wr_cc && wb_dat_i[2] && !wb_dat_i[0] && $past(clock_gen_ctl_line)
        |-> !clock_gen_ctl_line)
        else $error("latched write gave no pulse");
    a_pulse_width: assert property (mode_q && $fell(clock_gen_ctl_line) |=> !clock_gen_ctl_line ##1 clock_gen_ctl_line)
        else $error("pulse width not two cycles");
    a_byte_hold: assert property (mode_q && !clock_gen_ctl_line |=> $stable(companion_addr_lines))
        else $error("power byte moved during pulse");
    a_no_pulse: assert property (mode_q && wr_cc && wb_dat_i[0] && clock_gen_ctl_line |=> clock_gen_ctl_line [*3])
        else $error("write of one started a pulse");
    a_deturbo_dec: assert property (!wr_cc |-> deturbo_via_pin == !dt_q[0] && deturbo_smi_req == &dt_q)
        else $error("deturbo decode wrong");
    a_power_byte: assert property (wr_pw |=> companion_addr_lines == $past(wb_dat_i[7:0]))
        else $error("power byte not on address lines");
    a_backoff_len: assert property (bo_q && $fell(cpu_backoff) |-> hi_q == 11'h5DC)
        else $error("back-off run not 1500 cycles");
endmodule // pmcg_top_checker
bind pmcg_top pmcg_top_checker u_chk (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .clock_gen_ctl_line, .companion_addr_lines, .deturbo_via_pin, .deturbo_smi_req, .cpu_backoff);

// [verification/tb_pmcg_top.sv]
// Self-checking testbench for the PM clock block
`timescale 1ns/1ps
module tb_pmcg_top;
    import pmcg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, io_wr_valid = 1'b0, io_evt_hit;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic [15:0] io_wr_addr = 16'h0000, io_evt_addr = 16'h0470, io_evt_ref = 16'h0070;
    logic [7:0] io_wr_data = 8'h00, timer_cfg0, timer_cfg1, timer_cfg2, companion_addr_lines, latched;
    logic [3:0] timer_count0 = 4'h9, timer_count1 = 4'h6, timer_count2 = 4'h3;
    logic clock_gen_ctl_line, deturbo_via_pin, deturbo_smi_req, cpu_backoff, resume_indicator;
    int error_cnt = 0;
    int tests_run = 0;
    logic [7:0] rq;
    int n;
    // 250 MHz clock
    always #2 clk = ~clk;
    pmcg_top u_dut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .io_wr_valid, .io_wr_addr, .io_wr_data, .io_evt_addr, .io_evt_ref, .io_evt_hit, .timer_count0,
        .timer_count1, .timer_count2, .timer_cfg0, .timer_cfg1, .timer_cfg2, .clock_gen_ctl_line,
        .companion_addr_lines, .deturbo_via_pin, .deturbo_smi_req, .cpu_backoff, .resume_indicator);
    pmcg_latch_model u_latch (.clock_gen_ctl_line, .companion_addr_lines, .power_latch_value(latched));
    // Verdict and end of run
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One classic cycle; holds everything until ack is sampled, bounded wait
    task automatic bus(input logic we, input logic [9:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        do
        begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rq = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 20)
        begin
            error_cnt++;
            $display("mismatch bus ack expected 1 seen timeout");
            wrap_up();
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, {8'h00, e}, {8'h00, rq});
    endtask
    // Wait whole cycles, then sample settled outputs
    task automatic wait_cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // One snooped I/O write
    task automatic snoop(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_wr_valid <= 1'b1;
        io_wr_addr <= a;
        io_wr_data <= d;
        @(posedge clk);
        io_wr_valid <= 1'b0;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd("misc", 10'h0F4, 8'h01);
        rd("shadow", 10'h0FC, 8'h00);
        rd("clock_gen_ctl_pin", 10'h100, 8'h03);
        rd("power", 10'h104, 8'h00);
        rd("reserved", 10'h0F8, 8'h00);
        rd("unmapped", 10'h3FC, 8'h00);
        $display("test reset done");
        // Level mode: pin and status bit follow bit 0
        wr(10'h100, 8'h00);
        wait_cyc(2);
        chk("pin", 16'h0000, {15'h0000, clock_gen_ctl_line});
        rd("clock_gen_ctl_pin", 10'h100, 8'h00);
        wr(10'h100, 8'h01);
        rd("clock_gen_ctl_pin", 10'h100, 8'h03);
        $display("test level done");
        // Every deturbo code, then the back-off duty
        for (int i = 0; i < 4; i++)
        begin
            wr(10'h100, {3'b000, 2'(i), 3'b001});
            wait_cyc(2);
            chk("via_pin", {15'h0000, i[0] == 1'b0}, {15'h0000, deturbo_via_pin});
            chk("smi", {15'h0000, i == 3}, {15'h0000, deturbo_smi_req});
        end
        wr(10'h100, 8'h29);
        wait_cyc(8);
        n = 0;
        repeat (2000)
        begin
            @(posedge clk);
            if (cpu_backoff === 1'b1)
                n++;
        end
        chk("backoff", 16'h05DC, 16'(n));
        wr(10'h100, 8'h01);
        $display("test deturbo done");
        // Decode width, shadow capture and event compare
        snoop(16'h0470, 8'h11);
        rd("shadow", 10'h0FC, 8'h00);
        chk("evt_hit", 16'h0000, {15'h0000, io_evt_hit});
        snoop(16'h0070, 8'h33);
        rd("shadow", 10'h0FC, 8'h33);
        wr(10'h0F4, 8'h00);
        snoop(16'h0470, 8'h44);
        wait_cyc(2);
        chk("evt_hit", 16'h0001, {15'h0000, io_evt_hit});
        wr(10'h0FC, 8'hEE);
        rd("shadow", 10'h0FC, 8'h44);
        $display("test decode done");
        // Timer nibble selection and override
        wr(10'h0E4, 8'h20);
        rd("timer0", 10'h0E4, 8'h20);
        wr(10'h0E4, 8'h28);
        rd("timer0", 10'h0E4, 8'h98);
        wr(10'h0E4, 8'h20);
        wr(10'h0F4, 8'h06);
        rd("timer0", 10'h0E4, 8'h90);
        rd("timer1", 10'h0E8, 8'h60);
        wr(10'h0EC, 8'h50);
        rd("timer2", 10'h0EC, 8'h30);
        chk("cfg1", 16'h0000, {8'h00, timer_cfg1});
        chk("cfg2", 16'h0050, {8'h00, timer_cfg2});
        chk("cfg0", 16'h0020, {8'h00, timer_cfg0});
        chk("resume", 16'h0001, {15'h0000, resume_indicator});
        $display("test timer done");
        // Power byte, then latched capture by the external latch
        wr(10'h104, 8'hA5);
        wait_cyc(1);
        chk("power lines", 16'h00A5, {8'h00, companion_addr_lines});
        wr(10'h100, 8'h05);
        wait_cyc(4);
        chk("pin", 16'h0001, {15'h0000, clock_gen_ctl_line});
        // Latch still holds the zero byte it saw while the pin was low in level mode
        chk("latch", 16'h0000, {8'h00, latched});
        wr(10'h100, 8'h04);
        wait_cyc(8);
        chk("latch", 16'h00A5, {8'h00, latched});
        rd("clock_gen_ctl_pin", 10'h100, 8'h07);
        // A latched write of 1 must leave the pin high and the latch closed
        wr(10'h104, 8'h3C);
        wr(10'h100, 8'h05);
        wait_cyc(4);
        chk("pin", 16'h0001, {15'h0000, clock_gen_ctl_line});
        chk("latch", 16'h00A5, {8'h00, latched});
        $display("test latched done");
        wrap_up();
    end
endmodule // tb_pmcg_top

// [verilog/pmcg_backoff_gen.sv]
// Periodic dummy back-off generator for the deturbo scheme
`timescale 1ns/1ps
module pmcg_backoff_gen
    import pmcg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control side
    pmcg_backoff_if.gen bo
);

    logic [10:0] phase_q; // Position within the period
    logic backoff_q; // Registered back-off level

    // Period counter; held at zero when idle so each enable starts a fresh period
    always_ff @(posedge clk)
    begin
        if (rst || !bo.enable)
        begin
            phase_q <= 11'h000;
        end
        else if (phase_q == BACKOFF_PERIOD_LAST)
        begin
            phase_q <= 11'h000;
        end
        else
        begin
            phase_q <= phase_q + 11'h001;
        end
    end

    // Back-off for the first part of each period
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            backoff_q <= 1'b0;
        end
        else
        begin
            backoff_q <= bo.enable && (phase_q < BACKOFF_ON_LEN);
        end
    end

    assign bo.backoff = backoff_q;

endmodule // pmcg_backoff_gen

// [verilog/pmcg_backoff_if.sv]
// Interface joining the top to the dummy back-off generator
`timescale 1ns/1ps
interface pmcg_backoff_if;
    logic enable; // Back-off scheme selected
    logic backoff; // CPU bus held off
    modport ctrl (output enable, input backoff);
    modport gen (input enable, output backoff);
endinterface

// [verilog/pmcg_pkg.sv]
// Package of register indices, field positions, reset values and timing counts for the PM clock block
package pmcg_pkg;

    // Clock rate
    localparam int unsigned CLK_PERIOD_NS = 4;

    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_TIMER0 = 8'h39;
    localparam logic [7:0] IDX_TIMER1 = 8'h3A;
    localparam logic [7:0] IDX_TIMER2 = 8'h3B;
    localparam logic [7:0] IDX_MISC = 8'h3D;
    localparam logic [7:0] IDX_RSVD = 8'h3E;
    localparam logic [7:0] IDX_SHADOW = 8'h3F;
    localparam logic [7:0] IDX_CLOCK_GEN_CTL_PIN = 8'h40;
    localparam logic [7:0] IDX_POWER = 8'h41;
    localparam int unsigned NUM_TIMERS = 3;

    // Reset values
    localparam logic [7:0] RST_MISC = 8'h01;
    localparam logic [7:0] RST_SHADOW = 8'h00;
    localparam logic [7:0] RST_CLOCK_GEN_CTL_PIN = 8'h03;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_TIMER = 8'h00;

    // Miscellaneous register fields
    localparam int unsigned MISC_FULL_DECODE = 0;
    localparam int unsigned MISC_TMR_OVERRIDE = 1;
    localparam int unsigned MISC_RESUME = 2;

    // Clock-control register fields
    localparam int unsigned CC_CTL = 0;
    localparam int unsigned CC_STATUS = 1;
    localparam int unsigned CC_LATCH_MODE = 2;
    localparam int unsigned CC_DETURBO_LO = 3;
    localparam int unsigned CC_DETURBO_HI = 4;
    localparam int unsigned CC_BACKOFF = 5;

    // Timer register fields
    localparam int unsigned TMR_READ_SEL = 3;

    // Deturbo select codes
    localparam logic [1:0] DT_PIN_A = 2'b00;
    localparam logic [1:0] DT_RSVD = 2'b01;
    localparam logic [1:0] DT_PIN_B = 2'b10;
    localparam logic [1:0] DT_SMI = 2'b11;

    // Address decode
    localparam logic [15:0] RTC_INDEX_PORT = 16'h0070;
    localparam logic [15:0] DECODE_MASK_FULL = 16'hFFFF;
    localparam logic [15:0] DECODE_MASK_ISA = 16'h03FF;

    // Latched-mode pulse width
    localparam int unsigned PULSE_LOW_CYCLES = 2;
    localparam logic [3:0] PULSE_LAST = 4'(PULSE_LOW_CYCLES - 1);

    // Dummy back-off timing, as printed in microseconds
    localparam int unsigned BACKOFF_PERIOD_US = 8;
    localparam int unsigned BACKOFF_ON_US = 6;
    localparam int unsigned BACKOFF_PERIOD_CYC = (BACKOFF_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned BACKOFF_ON_CYC = (BACKOFF_ON_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] BACKOFF_PERIOD_LAST = 11'(BACKOFF_PERIOD_CYC - 1);
    localparam logic [10:0] BACKOFF_ON_LEN = 11'(BACKOFF_ON_CYC);

    // Pulse sequencer states, Gray from IDLE to LOW to DONE; the return from DONE to IDLE flips both bits
    typedef enum logic [1:0] {
        PULSE_IDLE = 2'b00,
        PULSE_LOW = 2'b01,
        PULSE_DONE = 2'b11
    } pmcg_pulse_t;

endpackage

// [verilog/pmcg_top.sv]
// Power-management clock-generator control, power latch and misc controls with a Wishbone slave
//
// Summary of operation
// - Decode bit picks 16 or 10 address lines
// - Override bit forces timer nibble to count
// - Port 70h writes captured in shadow
// - Level mode: pin follows control bit
// - Bit 1 reads pin level
// - Latched mode: write 0 pulses pin low
// - After pulse control and status return 1
// - Deturbo select picks pin or SMI method
// - Dummy back-off 6us of every 8us
// - Clock-control register resets to 03h
// - Power byte drives companion address lines
// - Misc register resets to 01h
// - Timer select bit picks count or setting
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module pmcg_top
    import pmcg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // I/O write snoop for the RTC index port
    input wire logic io_wr_valid,
    input wire logic [15:0] io_wr_addr,
    input wire logic [7:0] io_wr_data,
    // I/O event compare for the power-management unit
    input wire logic [15:0] io_evt_addr,
    input wire logic [15:0] io_evt_ref,
    output logic io_evt_hit,
    // Timers, kept outside
    input wire logic [3:0] timer_count0,
    input wire logic [3:0] timer_count1,
    input wire logic [3:0] timer_count2,
    output logic [7:0] timer_cfg0,
    output logic [7:0] timer_cfg1,
    output logic [7:0] timer_cfg2,
    // Clock generator and power latch
    output logic clock_gen_ctl_line,
    output logic [7:0] companion_addr_lines,
    // Deturbo and resume indication
    output logic deturbo_via_pin,
    output logic deturbo_smi_req,
    output logic cpu_backoff,
    output logic resume_indicator
);

    // Bus request decode
    logic bus_req; // Request waiting for an answer
    logic bus_wr; // Write strobe on lane 0 at the answer edge
    logic [7:0] reg_idx; // Register index from the word address
    logic [7:0] wdat; // Low byte of the write data
    logic ack_q; // Registered acknowledge
    logic [31:0] rdat_q; // Registered read data
    logic [7:0] rd_byte; // Read mux result

    // Register storage
    logic [7:0] misc_q; // Miscellaneous controls
    logic [7:0] shadow_q; // RTC index shadow
    logic [7:0] clock_gen_ctl_pin_q; // Clock-control bits, status bit unused
    logic [7:0] power_q; // Power-control byte
    logic [7:0] timer_q [NUM_TIMERS]; // Timer setting registers
    logic [3:0] timer_cnt [NUM_TIMERS]; // Timer current counts

    // Pulse sequencer
    pmcg_pulse_t pulse_q; // Sequencer state
    pmcg_pulse_t pulse_d; // Next state
    logic [3:0] pulse_cnt_q; // Low-phase cycle count
    logic pulse_start; // Latched-mode trigger write
    logic pin_q; // Registered control pin level
    logic evt_hit_q; // Registered event compare

    // Back-off generator link
    pmcg_backoff_if bo_if ();

    // Address compare over the selected number of lines
    function automatic logic addr_match(input logic full, input logic [15:0] a, input logic [15:0] b);
        logic [15:0] mask;
        mask = full ? DECODE_MASK_FULL : DECODE_MASK_ISA;
        addr_match = ((a & mask) == (b & mask));
    endfunction

    // Upper nibble of a timer register: count or setting
    function automatic logic [7:0] timer_view(input logic force_cnt, input logic [7:0] cfg, input logic [3:0] cnt);
        timer_view = (force_cnt || cfg[TMR_READ_SEL]) ? {cnt, cfg[3:0]} : cfg;
    endfunction

    assign timer_cnt[0] = timer_count0;
    assign timer_cnt[1] = timer_count1;
    assign timer_cnt[2] = timer_count2;

    // A request is answered once; ack low between requests
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    // Writes take effect on the edge where ack rises
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign reg_idx = wb_adr_i[9:2];
    assign wdat = wb_dat_i[7:0];

    // Acknowledge one cycle after the request, dropped the cycle after
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= bus_req;
        end
    end

    // Read mux; reserved and unmapped slots read zero
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (reg_idx)
            IDX_TIMER0: rd_byte = timer_view(misc_q[MISC_TMR_OVERRIDE], timer_q[0], timer_cnt[0]);
            IDX_TIMER1: rd_byte = timer_view(misc_q[MISC_TMR_OVERRIDE], timer_q[1], timer_cnt[1]);
            IDX_TIMER2: rd_byte = timer_view(misc_q[MISC_TMR_OVERRIDE], timer_q[2], timer_cnt[2]);
            IDX_MISC: rd_byte = misc_q;
            IDX_SHADOW: rd_byte = shadow_q;
            IDX_CLOCK_GEN_CTL_PIN: rd_byte = {clock_gen_ctl_pin_q[7:2], pin_q, clock_gen_ctl_pin_q[CC_CTL]};
            IDX_POWER: rd_byte = power_q;
            default: rd_byte = 8'h00;
        endcase
    end

    // Read data captured at the answer edge and held until the next one
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdat_q <= 32'h0000_0000;
        end
        else if (bus_req)
        begin
            rdat_q <= {24'h00_0000, rd_byte};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Miscellaneous register; upper bits stored as written, software keeps them zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            misc_q <= RST_MISC;
        end
        else if (bus_wr && reg_idx == IDX_MISC)
        begin
            misc_q <= wdat;
        end
    end

    // Timer setting registers handed to the timers outside
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                timer_q[i] <= RST_TIMER;
            end
        end
        else if (bus_wr)
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                if (reg_idx == IDX_TIMER0 + 8'(i))
                begin
                    timer_q[i] <= wdat;
                end
            end
        end
    end

    assign timer_cfg0 = timer_q[0];
    assign timer_cfg1 = timer_q[1];
    assign timer_cfg2 = timer_q[2];

    // Shadow of the RTC index port; not writable from the bus
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shadow_q <= RST_SHADOW;
        end
        else if (io_wr_valid && addr_match(misc_q[MISC_FULL_DECODE], io_wr_addr, RTC_INDEX_PORT))
        begin
            shadow_q <= io_wr_data;
        end
    end

    // Power-management I/O event compare, width set by the decode bit
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            evt_hit_q <= 1'b0;
        end
        else
        begin
            evt_hit_q <= addr_match(misc_q[MISC_FULL_DECODE], io_evt_addr, io_evt_ref);
        end
    end

    assign io_evt_hit = evt_hit_q;
    // Handler raises this just before leaving SMM; left for software to clear
    assign resume_indicator = misc_q[MISC_RESUME];

    // A trigger needs latched mode, a 0 in bit 0, and an idle sequencer
    assign pulse_start = bus_wr && reg_idx == IDX_CLOCK_GEN_CTL_PIN && clock_gen_ctl_pin_q[CC_LATCH_MODE] && !wdat[CC_CTL]
        && pulse_q == PULSE_IDLE;

    // Clock-control register; bit 0 returns high when the pulse ends
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            clock_gen_ctl_pin_q <= RST_CLOCK_GEN_CTL_PIN;
        end
        else if (pulse_q == PULSE_DONE)
        begin
            clock_gen_ctl_pin_q[CC_CTL] <= 1'b1;
        end
        else if (bus_wr && reg_idx == IDX_CLOCK_GEN_CTL_PIN && pulse_q == PULSE_IDLE)
        begin
            // Mode bits and bit 0 stored; bit 1 is never stored
            clock_gen_ctl_pin_q[7:2] <= wdat[7:2];
            clock_gen_ctl_pin_q[CC_CTL] <= wdat[CC_CTL];
        end
    end

    // Next state of the pulse sequencer
    always_comb
    begin
        pulse_d = pulse_q;
        unique case (pulse_q)
            PULSE_IDLE:
            begin
                if (pulse_start)
                begin
                    pulse_d = PULSE_LOW;
                end
            end
            PULSE_LOW:
            begin
                if (pulse_cnt_q == PULSE_LAST)
                begin
                    pulse_d = PULSE_DONE;
                end
            end
            PULSE_DONE: pulse_d = PULSE_IDLE;
            default: pulse_d = PULSE_IDLE;
        endcase
    end

    // Sequencer state register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pulse_q <= PULSE_IDLE;
        end
        else
        begin
            pulse_q <= pulse_d;
        end
    end

    // Low-phase counter
    always_ff @(posedge clk)
    begin
        if (rst || pulse_q != PULSE_LOW)
        begin
            pulse_cnt_q <= 4'h0;
        end
        else
        begin
            pulse_cnt_q <= pulse_cnt_q + 4'h1;
        end
    end

    // Control pin: follows bit 0 in level mode, low only during the pulse in latched mode
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_q <= 1'b1;
        end
        else if (pulse_start)
        begin
            pin_q <= 1'b0;
        end
        else if (pulse_q == PULSE_LOW && pulse_cnt_q == PULSE_LAST)
        begin
            pin_q <= 1'b1;
        end
        else if (pulse_q == PULSE_IDLE && !clock_gen_ctl_pin_q[CC_LATCH_MODE])
        begin
            pin_q <= clock_gen_ctl_pin_q[CC_CTL];
        end
        else if (pulse_q == PULSE_IDLE)
        begin
            // Latched mode at rest keeps the pin high
            pin_q <= 1'b1;
        end
    end

    assign clock_gen_ctl_line = pin_q;

    // Power byte; writes during a pulse are dropped so the latch sees a steady value
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            power_q <= RST_POWER;
        end
        else if (bus_wr && reg_idx == IDX_POWER && pulse_q == PULSE_IDLE)
        begin
            power_q <= wdat;
        end
    end

    assign companion_addr_lines = power_q;

    // Deturbo scheme decode; the reserved code uses neither pin nor SMI
    always_comb
    begin
        deturbo_via_pin = 1'b0;
        deturbo_smi_req = 1'b0;
        bo_if.enable = 1'b0;
        unique case (clock_gen_ctl_pin_q[CC_DETURBO_HI:CC_DETURBO_LO])
            DT_PIN_A: deturbo_via_pin = 1'b1;
            DT_PIN_B: deturbo_via_pin = 1'b1;
            DT_SMI: deturbo_smi_req = 1'b1;
            DT_RSVD: bo_if.enable = clock_gen_ctl_pin_q[CC_BACKOFF];
        endcase
    end

    // Dummy back-off generator
    pmcg_backoff_gen u_backoff (
        .clk (clk),
        .rst (rst),
        .bo (bo_if.gen)
    );

    assign cpu_backoff = bo_if.backoff;

endmodule // pmcg_top
